// file: flash_front.v
// SPI slave command front end: status register, write latch, standard reads.
// Assumes the array answers arrayData one core_clk cycle after arrayAddr,
// and the program/erase engine reports engineBusy/engineDone on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_defs.vh"

module flash_front #(
  parameter ADDR_W    = `ARRAY_ADDR_W,
  parameter SW_CYCLES = `SW_CYCLES
) (
  input  wire              core_clk,
  input  wire              sys_rst,
  input  wire              serialClk,
  input  wire              chipSelectN,
  input  wire              serialIn,
  input  wire              writeProtectN,
  output reg               serialOut,
  output reg               serialOutEnN,
  output reg  [ADDR_W-1:0] arrayAddr,
  input  wire [7:0]        arrayData,
  input  wire [4:0]        nvStoredBits,
  output reg               nvWrite,
  output reg  [4:0]        nvWriteData,
  output reg               engineStart,
  output reg  [7:0]        engineOpcode,
  output reg  [23:0]       engineAddr,
  output reg               suspendReq,
  output reg               resumeReq,
  input  wire              engineBusy,
  input  wire              engineDone,
  output wire [7:0]        flashStatus
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CMD  = 3'b010;
  localparam ST_OUT  = 3'b100;

  wire       sckS;
  wire       csNS;
  wire       siS;
  wire       wpNS;
  reg        sckPrev_q;
  reg        csPrev_q;
  reg  [2:0] state_q;
  reg  [5:0] riseCnt_q;
  reg  [7:0] rxShift_q;
  reg  [7:0] opcode_q;
  reg  [7:0] wrData_q;
  reg  [2:0] outBit_q;
  reg        isRead_q;
  reg        wel_q;
  reg        sus_q;
  reg  [2:0] bp_q;
  reg        tb_q;
  reg        lock_q;
  reg        swStart;
  wire       swBusy;
  wire       swDone;
  wire [7:0] rxNext;
  wire       sckRise;
  wire       sckFall;
  wire       csRise;
  wire       csFall;
  wire       busyBit;
  wire [7:0] outByte;

  // Pins come from the link domain: two flops each before use
  pin_sync #(.WIDTH(4)) uSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .resetVal (4'hB),
    .pinIn    ({writeProtectN, serialIn, chipSelectN, serialClk}),
    .pinOut   ({wpNS, siS, csNS, sckS})
  );

  status_write_timer #(.CYCLES(SW_CYCLES)) uSwTimer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (swStart),
    .busy     (swBusy),
    .done     (swDone)
  );

  // True for any opcode that starts an erase or program in the engine
  function isEraseProgram;
    input [7:0] op;
    begin
      isEraseProgram = (op == `OP_SSE_A) || (op == `OP_SSE_B) ||
                       (op == `OP_SECTOR_ERASE) || (op == `OP_CHIP_ERASE_A) ||
                       (op == `OP_CHIP_ERASE_B) || (op == `OP_PAGE_PROGRAM) ||
                       (op == `OP_LP_PROGRAM);
    end
  endfunction

  // Edges of the sampled link clock and select; only clock edges inside a frame count
  assign sckRise = sckS && !sckPrev_q && !csNS;
  assign sckFall = !sckS && sckPrev_q && !csNS;
  assign csRise  = csNS && !csPrev_q;
  assign csFall  = !csNS && csPrev_q;
  assign rxNext  = {rxShift_q[6:0], siS};

  // Busy while a status write runs or the engine works unsuspended
  assign busyBit     = swBusy | (engineBusy & ~sus_q);
  assign flashStatus = {lock_q, sus_q, tb_q, bp_q, wel_q, busyBit};
  assign outByte     = isRead_q ? arrayData : flashStatus;

  // Previous synced levels for edge detection
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sckPrev_q <= 1'b1;                                               // Matches sync reset level
      csPrev_q  <= 1'b1;
    end else begin
      sckPrev_q <= sckS;
      csPrev_q  <= csNS;
    end
  end

  // Frame sequencer: counting rises makes mode 0 and 3 behave alike,
  // since a leading falling edge in mode 3 finds nothing to shift yet
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_q   <= ST_IDLE;
      riseCnt_q <= 6'd0;
      rxShift_q <= 8'h00;
      opcode_q  <= 8'h00;
      wrData_q  <= 8'h00;
      isRead_q  <= 1'b0;
      arrayAddr <= {ADDR_W{1'b0}};
      engineAddr <= 24'h0;
    end else if (csNS) begin
      state_q   <= ST_IDLE;
      riseCnt_q <= 6'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (csFall) begin
            state_q   <= ST_CMD;
            riseCnt_q <= 6'd0;
            isRead_q  <= 1'b0;
          end
        end
        ST_CMD, ST_OUT: begin
          if (sckRise) begin
            rxShift_q <= rxNext;
            if (riseCnt_q != 6'h3F) begin
              riseCnt_q <= riseCnt_q + 6'd1;
            end
            if (riseCnt_q == `CNT_OPCODE - 6'd1) begin
              opcode_q <= rxNext;
              if (rxNext == `OP_STATUS_READ) begin
                state_q <= ST_OUT;
              end
            end
            if (riseCnt_q == `CNT_WR_DATA - 6'd1) begin
              wrData_q <= rxNext;
            end
            if (riseCnt_q >= `CNT_OPCODE && riseCnt_q < `CNT_ADDR) begin
              engineAddr <= {engineAddr[22:0], siS};
            end
            if (riseCnt_q == `CNT_ADDR - 6'd1) begin
              // Upper three address bits dropped by the width
              arrayAddr <= {engineAddr[ADDR_W-2:0], siS};
              if (opcode_q == `OP_LOW_POWER_READ) begin
                state_q  <= ST_OUT;
                isRead_q <= 1'b1;
              end
            end
            if (riseCnt_q == `CNT_DUMMY - 6'd1 &&
                opcode_q == `OP_FAST_READ) begin
              state_q  <= ST_OUT;
              isRead_q <= 1'b1;
            end
          end
          // Advance once the last bit of a byte has gone out
          if (sckFall && state_q == ST_OUT && isRead_q &&
              outBit_q == 3'd7) begin
            arrayAddr <= arrayAddr + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Output shifter: one bit per falling edge, MSB first; the status byte repeats, array reads advance the address
  always @(posedge core_clk) begin
    if (sys_rst) begin
      serialOut    <= 1'b0;
      serialOutEnN <= 1'b1;
      outBit_q     <= 3'd0;
    end else if (csNS || state_q != ST_OUT) begin
      serialOutEnN <= 1'b1;
      outBit_q     <= 3'd0;
    end else if (sckFall) begin
      serialOut    <= outByte[3'd7 - outBit_q];
      serialOutEnN <= 1'b0;
      outBit_q     <= outBit_q + 3'd1;
    end
  end

  // Commands take effect at the rise of chip select
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wel_q        <= `ST_VOLATILE_RESET;
      sus_q        <= `ST_VOLATILE_RESET;
      bp_q         <= nvStoredBits[2:0];
      tb_q         <= nvStoredBits[3];
      lock_q       <= nvStoredBits[4];
      swStart      <= 1'b0;
      nvWrite      <= 1'b0;
      nvWriteData  <= 5'h00;
      engineStart  <= 1'b0;
      engineOpcode <= 8'h00;
      suspendReq   <= 1'b0;
      resumeReq    <= 1'b0;
    end else begin
      swStart     <= 1'b0;
      nvWrite     <= 1'b0;
      engineStart <= 1'b0;
      suspendReq  <= 1'b0;
      resumeReq   <= 1'b0;
      // Completion clears the latch; a new set in the same cycle wins
      if (swDone || engineDone) begin
        wel_q <= 1'b0;
      end
      if (csRise && state_q != ST_IDLE && riseCnt_q == `CNT_OPCODE) begin
        case (opcode_q)
          `OP_WRITE_ENABLE:  wel_q <= 1'b1;
          `OP_WRITE_DISABLE: wel_q <= 1'b0;
          `OP_SUSPEND: begin
            if (engineBusy && !sus_q) begin
              sus_q      <= 1'b1;
              suspendReq <= 1'b1;
            end
          end
          `OP_RESUME: begin
            if (sus_q) begin
              sus_q     <= 1'b0;
              resumeReq <= 1'b1;
            end
          end
          `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
            if (wel_q && !busyBit && !swBusy) begin
              engineStart  <= 1'b1;
              engineOpcode <= opcode_q;
              sus_q        <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      // Status write needs exactly one data byte and an enabled latch
      if (csRise && state_q != ST_IDLE && riseCnt_q == `CNT_WR_DATA &&
          opcode_q == `OP_STATUS_WRITE && wel_q && !busyBit &&
          (wpNS || !lock_q)) begin
        bp_q        <= wrData_q[`ST_BP_MSB:`ST_BP_LSB];
        tb_q        <= wrData_q[`ST_TB_BIT];
        lock_q      <= wrData_q[`ST_LOCK_BIT];
        nvWrite     <= 1'b1;
        nvWriteData <= {wrData_q[`ST_LOCK_BIT], wrData_q[`ST_TB_BIT],
                        wrData_q[`ST_BP_MSB:`ST_BP_LSB]};
        swStart     <= 1'b1;
      end
      // Addressed erase and program commands need the full address
      if (csRise && state_q != ST_IDLE && riseCnt_q >= `CNT_ADDR &&
          isEraseProgram(opcode_q) && opcode_q != `OP_CHIP_ERASE_A &&
          opcode_q != `OP_CHIP_ERASE_B && wel_q && !busyBit && !swBusy) begin
        engineStart  <= 1'b1;
        engineOpcode <= opcode_q;
        sus_q        <= 1'b0;
      end
    end
  end

endmodule // flash_front

`default_nettype wire

// file: flash_front_defs.vh
// Constants for the serial flash status and read front end.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef FLASH_FRONT_DEFS_VH
`define FLASH_FRONT_DEFS_VH

// Command opcodes
`define OP_STATUS_READ     8'h05
`define OP_STATUS_WRITE    8'h01
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define OP_LOW_POWER_READ  8'h03
`define OP_FAST_READ       8'h0B
`define OP_SUSPEND         8'hB0
`define OP_RESUME          8'h30
`define OP_SSE_A           8'h20
`define OP_SSE_B           8'hD7
`define OP_SECTOR_ERASE    8'hD8
`define OP_CHIP_ERASE_A    8'h60
`define OP_CHIP_ERASE_B    8'hC7
`define OP_PAGE_PROGRAM    8'h02
`define OP_LP_PROGRAM      8'h0A

// Status byte bit positions
`define ST_BUSY_BIT        0
`define ST_WEL_BIT         1
`define ST_BP_LSB          2
`define ST_BP_MSB          4
`define ST_TB_BIT          5
`define ST_SUS_BIT         6
`define ST_LOCK_BIT        7

// Reset value of the volatile status bits
`define ST_VOLATILE_RESET  1'b0

// Rising-edge counts at which a frame reaches each phase
`define CNT_OPCODE         6'd8
`define CNT_WR_DATA        6'd16
`define CNT_ADDR           6'd32
`define CNT_DUMMY          6'd40

// Array address width (upper three address bits ignored)
`define ARRAY_ADDR_W       21

// Status write time and its cycle count at 100 MHz, the exact product of the two
`define CLK_MHZ            100
`define SW_TIME_US         5
`define SW_CYCLES          (`SW_TIME_US * `CLK_MHZ)

`endif

// file: pin_sync.v
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level or a clock far below core_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 4
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] resetVal,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinOut
);

  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      always @(posedge core_clk) begin
        if (sys_rst) begin
          meta_q[i] <= resetVal[i];
          pinOut[i] <= resetVal[i];
        end else begin
          meta_q[i] <= pinIn[i];
          pinOut[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

// file: status_write_timer.v
// Busy timer for the nonvolatile status write.
// Assumes start is a one-cycle pulse; restarts are ignored while busy.
`timescale 1ns/1ps
`default_nettype none

module status_write_timer #(
  parameter CYCLES = 500
) (
  input  wire core_clk,
  input  wire sys_rst,
  input  wire start,
  output reg  busy,
  output reg  done
);

  reg [31:0] count_q;

  // Count down the write time, pulse done in the cycle busy falls
  always @(posedge core_clk) begin
    if (sys_rst) begin
      count_q <= 32'h0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        count_q <= CYCLES;
        busy    <= 1'b1;
      end else if (busy) begin
        if (count_q <= 32'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - 32'h1;
        end
      end
    end
  end

endmodule // status_write_timer

`default_nettype wire

// file: flash_front_assertions.sv
// Port-level checks for the flash front end.
// Assumes one core_clk domain and binding onto flash_front.
`timescale 1ns/1ps
`default_nettype none
module flash_front_checker #(
  parameter SW_CYCLES = 500
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       serialClk,
  input wire logic       chipSelectN,
  input wire logic       serialOut,
  input wire logic       serialOutEnN,
  input wire logic       nvWrite,
  input wire logic       suspendReq,
  input wire logic       resumeReq,
  input wire logic       engineBusy,
  input wire logic       engineDone,
  input wire logic [7:0] flashStatus
);
  // Busy falls the write time after it rises; slack covers the timer start
  localparam int SwLo = SW_CYCLES - 10;
  localparam int SwHi = SW_CYCLES - 5;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_idle_out_off: assert property (chipSelectN [*6] |-> serialOutEnN)
    else $error("output driven while deselected");
  a_release_on_cs: assert property ($rose(chipSelectN) |-> ##[1:5] serialOutEnN)
    else $error("output not released after frame end");
  a_shift_on_fall: assert property (
    !serialOutEnN && !$past(serialOutEnN) && $changed(serialOut) |-> !serialClk)
    else $error("output bit changed while serial clock high");
  a_busy_engine: assert property (engineBusy && !flashStatus[6] |-> flashStatus[0])
    else $error("busy bit low while engine runs");
  a_sus_set: assert property (suspendReq |-> ##[0:2] flashStatus[6])
    else $error("suspend flag not set");
  a_sus_legal: assert property (
    suspendReq |-> $past(engineBusy) && !$past(flashStatus[6]))
    else $error("suspend accepted with nothing to suspend");
  a_sus_clear: assert property (resumeReq |-> ##[0:2] !flashStatus[6])
    else $error("suspend flag not cleared by resume");
  a_sw_needs_wel: assert property (nvWrite |-> chipSelectN && flashStatus[1])
    else $error("status write without latch or inside frame");
  a_sw_busy_time: assert property (
    nvWrite && !engineBusy |=> flashStatus[0] [*8] ##[SwLo:SwHi] $fell(flashStatus[0]))
    else $error("status write busy time wrong");
  a_wel_clear_done: assert property (engineDone && chipSelectN |=> !flashStatus[1])
    else $error("latch kept after engine completion");
  a_wel_clear_sw: assert property (
    $fell(flashStatus[0]) && !engineBusy && !$past(engineBusy) |-> ##[0:1] !flashStatus[1])
    else $error("latch kept after status write");
endmodule // flash_front_checker

bind flash_front flash_front_checker #(.SW_CYCLES(SW_CYCLES)) u_flash_front_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .serialClk(serialClk),
  .chipSelectN(chipSelectN), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
  .nvWrite(nvWrite), .suspendReq(suspendReq), .resumeReq(resumeReq),
  .engineBusy(engineBusy), .engineDone(engineDone), .flashStatus(flashStatus)
);
`default_nettype wire

// file: spi_host_model.sv
// Host side of the serial link: frames, clock mode 0 or 3.
// Assumes the device shifts its reply out on falling clock edges.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sck,
  output logic csN,
  output logic mosi,
  input  wire logic miso,
  input  wire logic misoEnN
);
  logic        cpol = 1'b0;  // Idle clock level, high for mode 3
  logic [63:0] rxBits;
  event        rxDone;
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b1;
  end
  // Clock stands still between frames; a released data line flips so stale bits show
  task automatic frame(input int n, input logic [63:0] tx);
    #7 sck = cpol;
    #30 csN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #80 sck = 1'b0;
      mosi = tx[i];
      #80 sck = 1'b1;
      rxBits = {rxBits[62:0], misoEnN === 1'b0 ? miso : 1'bx};
    end
    #80 sck = cpol;
    #80 csN = 1'b1;
    mosi = ~mosi;
    -> rxDone;
    #303; // Whole core periods per frame keep pin changes off core edges
  endtask
endmodule // spi_host_model
`default_nettype wire

// file: flash_front_tb.sv
// Self-checking bench for flash_front with a host model on the link.
// Assumes the checker bind and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_defs.vh"
module flash_front_tb;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        writeProtectN = 1'b0;
  logic        engineBusy = 1'b0;
  logic        engineDone = 1'b0;
  logic [7:0]  arrayData = 8'h00;
  logic [4:0]  nvStoredBits = 5'h00;
  wire         sck, csN, mosi, serialOut, serialOutEnN, nvWrite, suspendReq, resumeReq;
  wire         engineStart;
  wire  [7:0]  engineOpcode;
  wire  [23:0] engineAddr;
  wire  [20:0] arrayAddr;
  wire  [4:0]  nvWriteData;
  wire  [7:0]  flashStatus;
  logic [63:0] expQ[$], maskQ[$];
  logic [4:0]  nvQ[$];
  logic [31:0] engQ[$];
  logic [23:0] addr;
  logic [4:0]  nv;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  flash_front #(.SW_CYCLES(600)) u_flash_front (
    .core_clk(core_clk), .sys_rst(sys_rst), .serialClk(sck), .chipSelectN(csN),
    .serialIn(mosi), .writeProtectN(writeProtectN), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN), .arrayAddr(arrayAddr), .arrayData(arrayData),
    .nvStoredBits(nvStoredBits), .nvWrite(nvWrite), .nvWriteData(nvWriteData),
    .engineStart(engineStart), .engineOpcode(engineOpcode), .engineAddr(engineAddr),
    .suspendReq(suspendReq),
    .resumeReq(resumeReq), .engineBusy(engineBusy), .engineDone(engineDone),
    .flashStatus(flashStatus)
  );
  spi_host_model u_host (
    .sck(sck), .csN(csN), .mosi(mosi), .miso(serialOut), .misoEnN(serialOutEnN)
  );

  // Array contents, answered one cycle after the address
  function automatic logic [7:0] mem(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'b000, a[20:16]};
  endfunction
  always @(posedge core_clk) arrayData <= mem(arrayAddr);

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Note the reply first so the monitor never runs ahead of it
  task automatic xfer(input int n, input logic [63:0] tx, input logic [63:0] exp,
                      input logic [63:0] mask);
    expQ.push_back(exp & mask);
    maskQ.push_back(mask);
    u_host.frame(n, tx);
  endtask

  task automatic cmd(input logic [7:0] op);
    xfer(8, {56'h0, op}, 64'h0, 64'h0);
  endtask

  // 24 clocks, so the status byte comes out twice
  task automatic status_read_cmd(input logic [7:0] st);
    xfer(24, {40'h0, `OP_STATUS_READ, 16'h0}, {48'h0, st, st}, 64'hFFFF);
  endtask

  task automatic status_write_cmd(input logic [7:0] d);
    xfer(16, {48'h0, `OP_STATUS_WRITE, d}, 64'h0, 64'h0);
  endtask

  // Each finished frame against the oldest note
  always @(u_host.rxDone) begin
    check("frame", expQ.pop_front(), u_host.rxBits & maskQ.pop_front());
  end

  // A stored write with no note behind it is a refused write that went through
  always @(posedge core_clk) begin
    if (nvWrite === 1'b1) begin
      check("nvWriteData", nvQ.size() > 0 ? nvQ.pop_front() : 'x, nvWriteData);
    end
  end

  // An engine start with no note behind it is a refused command that went through
  always @(posedge core_clk) begin
    if (engineStart === 1'b1) begin
      check("engineStart", engQ.size() > 0 ? engQ.pop_front() : 'x, {engineOpcode, engineAddr});
    end
  end

  // Cycle ceiling against a hung link
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'h3A4B0C89));
    nv = 5'($urandom) & 5'h0F;
    addr = 24'($urandom);
    // Reset seen at two core edges, the second one with the stored bits in place
    @(posedge core_clk) nvStoredBits <= nv;
    @(posedge core_clk) sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    status_read_cmd({2'b00, nv[3:0], 2'b00});
    status_write_cmd(8'hFF);
    status_read_cmd({2'b00, nv[3:0], 2'b00});
    cmd(`OP_WRITE_ENABLE);
    status_read_cmd({2'b00, nv[3:0], 2'b10});
    u_host.cpol = 1'b1;
    cmd(`OP_WRITE_DISABLE);
    status_read_cmd({2'b00, nv[3:0], 2'b00});
    u_host.cpol = 1'b0;
    cmd(`OP_WRITE_ENABLE);
    nvQ.push_back(5'h1F);
    status_write_cmd(8'hFF);
    status_read_cmd(8'hBF);
    repeat (600) @(posedge core_clk);
    status_read_cmd(8'hBC);
    cmd(`OP_WRITE_ENABLE);
    status_write_cmd(8'h00);
    status_read_cmd(8'hBE);
    @(posedge core_clk) writeProtectN <= 1'b1;
    nvQ.push_back(5'h00);
    status_write_cmd(8'h00);
    repeat (700) @(posedge core_clk);
    status_read_cmd(8'h00);
    @(posedge core_clk) engineBusy <= 1'b1;
    cmd(`OP_SUSPEND);
    status_read_cmd(8'h40);
    cmd(`OP_RESUME);
    cmd(`OP_WRITE_ENABLE);
    status_read_cmd(8'h03);
    cmd(`OP_SUSPEND);
    status_read_cmd(8'h42);
    // A new erase while suspended starts and clears the suspend flag
    engQ.push_back({`OP_SECTOR_ERASE, addr});
    xfer(32, {32'h0, `OP_SECTOR_ERASE, addr}, 64'h0, 64'h0);
    status_read_cmd(8'h03);
    @(posedge core_clk) begin
      engineBusy <= 1'b0;
      engineDone <= 1'b1;
    end
    @(posedge core_clk) engineDone <= 1'b0;
    status_read_cmd(8'h00);
    xfer(32, {32'h0, `OP_SECTOR_ERASE, addr}, 64'h0, 64'h0);
    xfer(56, {8'h0, `OP_LOW_POWER_READ, addr, 24'h0}, {mem(addr[20:0]),
         mem(addr[20:0] + 21'd1), mem(addr[20:0] + 21'd2)}, 64'hFFFFFF);
    xfer(64, {`OP_FAST_READ, addr[23:21], 21'h1FFFFE, 8'h00, 24'h0}, {mem(21'h1FFFFE),
         mem(21'h1FFFFF), mem(21'h0)}, 64'hFFFFFF);
    check("queues left", 64'h0, 64'(expQ.size() + nvQ.size() + engQ.size()));
    end_of_test();
  end
endmodule // flash_front_tb
`default_nettype wire
